// ### hw/wpc_consts.vh
// constants for the wireless power phase controller
`ifndef WPPC_CONSTS_VH
`define WPPC_CONSTS_VH
// packet header codes
`define PH_SIG_STRENGTH 8'h01
`define PH_END_XFER 8'h02
`define PH_CTRL_ERR 8'h03
`define PH_RECT_PWR 8'h04
`define PH_CHG_STAT 8'h05
`define PH_HOLDOFF 8'h06
`define PH_PROP_A 8'h18
`define PH_PROP_B 8'hF2
`define PH_CONFIG 8'h51
`define PH_IDENT 8'h71
`define PH_EXT_IDENT 8'h81
// extended identification flag position in identification message byte
`define EXT_FLAG_BIT 7
// most optional packets before configuration
`define MAX_OPT_PKTS 4'h7
// inverter period in system cycles (125 MHz clock)
`define PER_PING 16'h02CA
`define PER_MIN 16'h0261
`define PER_MAX 16'h0470
// period step per unit of control error
`define PER_STEP 16'h0001
// phase codes
`define PHASE_SEL 3'h0
`define PHASE_PING 3'h1
`define PHASE_IDCFG 3'h2
`define PHASE_XFER 3'h3
`define PHASE_OFF 3'h4
`endif

// ### hw/wppc_timer.v
// down counter used for every phase timeout and delay
`timescale 1ns/1ns
module wppc_timer #(
    parameter W = 32
) (
    clk_sys,
    rst_n,
    load,
    load_val,
    expired_q,
    running_q
);
    input wire clk_sys;
    input wire rst_n;
    input wire load;
    input wire [W-1:0] load_val;
    output reg expired_q;
    output reg running_q;

    reg [W-1:0] cnt_q;

    // load restarts; expiry is a single pulse at count end
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            cnt_q <= {W{1'b0}};
            expired_q <= 1'b0;
            running_q <= 1'b0;
        end else if (load) begin
            cnt_q <= load_val;
            expired_q <= 1'b0;
            running_q <= 1'b1;
        end else if (running_q) begin
            if (cnt_q <= {{(W-1){1'b0}}, 1'b1}) begin
                expired_q <= 1'b1;
                running_q <= 1'b0;
            end else begin
                cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
                expired_q <= 1'b0;
            end
        end else begin
            expired_q <= 1'b0;
        end
    end
endmodule

// ### hw/wppc_phase_ctrl.v
// phase sequencer and power supervisor for the inductive transmitter
`timescale 1ns/1ns
`include "wpc_consts.vh"

module wppc_phase_ctrl #(
    parameter SEL_PERIOD_CYC = 32'd62500000,
    parameter SEL_BURST_CYC = 32'd8750000,
    parameter PING_WIN_CYC = 32'd8750000,
    parameter NEXT_PKT_CYC = 32'd2625000,
    parameter FIRST_CE_CYC = 32'd21250000,
    parameter CE_GAP_CYC = 32'd225000000,
    parameter RP_GAP_CYC = 32'd3000000000,
    parameter REMOVE_DLY_CYC = 32'd3125000,
    parameter SETTLE_CYC = 32'd625000
) (
    clk_sys,
    rst_n,
    hdr_start,
    pkt_valid,
    pkt_type,
    pkt_msg0,
    pkt_csum_ok,
    rx_seen,
    power_on_q,
    period_q,
    phase_q,
    fault_q
);
    input wire clk_sys;
    input wire rst_n;
    input wire hdr_start;
    input wire pkt_valid;
    input wire [7:0] pkt_type;
    input wire [7:0] pkt_msg0;
    input wire pkt_csum_ok;
    input wire rx_seen;
    output reg power_on_q;
    output reg [15:0] period_q;
    output reg [2:0] phase_q;
    output reg fault_q;

    // identification sub-states
    localparam ID_WAIT_ID = 2'b00;
    localparam ID_WAIT_EXT = 2'b01;
    localparam ID_WAIT_CFG = 2'b10;

    reg [1:0] id_st_q, id_st_d;
    reg [3:0] opt_cnt_q, opt_cnt_d;
    reg [2:0] phase_d;
    reg [31:0] tm_val;
    reg signed [7:0] ce_val_q;
    reg pend_ce_q, tmo_armed_q, tmo_armed_d;
    reg tm_load, rp_load, take_ce, fault_d, power_d;
    wire tm_exp, tm_run, rp_exp, st_exp, good_pkt;

    // only checksum-clean packets take part in sequencing
    assign good_pkt = pkt_valid & pkt_csum_ok;

    // reserved or proprietary header allowed among optional packets
    function is_optional;
        input [7:0] t;
        begin
            is_optional = (t == `PH_HOLDOFF) || (t == `PH_PROP_A) ||
                (t == `PH_PROP_B) ||
                !((t == `PH_SIG_STRENGTH) || (t == `PH_END_XFER) ||
                (t == `PH_CTRL_ERR) || (t == `PH_RECT_PWR) ||
                (t == `PH_CHG_STAT) || (t == `PH_IDENT) ||
                (t == `PH_EXT_IDENT) || (t == `PH_CONFIG));
        end
    endfunction

    // phase timer, rectified power timer and settling timer
    wppc_timer #(.W(32)) u_phase_tm (.clk_sys(clk_sys), .rst_n(rst_n),
        .load(tm_load), .load_val(tm_val), .expired_q(tm_exp),
        .running_q(tm_run));
    wppc_timer #(.W(32)) u_rp_tm (.clk_sys(clk_sys), .rst_n(rst_n),
        .load(rp_load), .load_val(RP_GAP_CYC), .expired_q(rp_exp),
        .running_q());
    wppc_timer #(.W(32)) u_settle_tm (.clk_sys(clk_sys), .rst_n(rst_n),
        .load(take_ce), .load_val(SETTLE_CYC), .expired_q(st_exp),
        .running_q());

    // next phase; header start disarms the gap timeout until packet ends
    always @* begin
        phase_d = phase_q;
        id_st_d = id_st_q;
        opt_cnt_d = opt_cnt_q;
        fault_d = 1'b0;
        power_d = power_on_q;
        tmo_armed_d = tmo_armed_q;
        tm_load = 1'b0;
        tm_val = PING_WIN_CYC;
        rp_load = 1'b0;
        take_ce = 1'b0;
        if (hdr_start)
            tmo_armed_d = 1'b0;
        if (pkt_valid && !pkt_csum_ok && (phase_q == `PHASE_PING ||
            phase_q == `PHASE_IDCFG)) begin
            tm_load = 1'b1; // corrupt packet must not stall the gap
            tm_val = NEXT_PKT_CYC;
            tmo_armed_d = 1'b1;
        end
        case (phase_q)
            `PHASE_SEL: begin
                // burst on a slow cadence; a response starts ping
                if (tm_exp || !tm_run) begin // idle after reset starts it
                    if (power_on_q && rx_seen) begin
                        phase_d = `PHASE_PING;
                        tm_load = 1'b1;
                        tm_val = PING_WIN_CYC;
                        tmo_armed_d = 1'b1;
                    end else begin
                        power_d = !power_on_q;
                        tm_load = 1'b1;
                        tm_val = power_on_q ?
                            SEL_PERIOD_CYC - SEL_BURST_CYC : SEL_BURST_CYC;
                    end
                end
            end
            `PHASE_PING: begin
                if (good_pkt) begin
                    if (pkt_type == `PH_SIG_STRENGTH) begin
                        phase_d = `PHASE_IDCFG;
                        id_st_d = ID_WAIT_ID;
                        opt_cnt_d = 4'h0;
                        tm_load = 1'b1;
                        tm_val = NEXT_PKT_CYC;
                        tmo_armed_d = 1'b1;
                    end else begin
                        fault_d = 1'b1;
                    end
                end else if (tm_exp && tmo_armed_q) begin
                    fault_d = 1'b1;
                end
            end
            `PHASE_IDCFG: begin
                tm_load = tm_load | good_pkt;
                tm_val = NEXT_PKT_CYC;
                if (good_pkt)
                    tmo_armed_d = 1'b1;
                if (tm_exp && tmo_armed_q) begin
                    fault_d = 1'b1;
                end else if (good_pkt) begin
                    case (id_st_q)
                        ID_WAIT_ID: begin
                            if (pkt_type != `PH_IDENT)
                                fault_d = 1'b1;
                            else if (pkt_msg0[`EXT_FLAG_BIT])
                                id_st_d = ID_WAIT_EXT;
                            else
                                id_st_d = ID_WAIT_CFG;
                        end
                        ID_WAIT_EXT: begin
                            if (pkt_type == `PH_EXT_IDENT)
                                id_st_d = ID_WAIT_CFG;
                            else
                                fault_d = 1'b1;
                        end
                        ID_WAIT_CFG: begin
                            if (pkt_type == `PH_CONFIG) begin
                                phase_d = `PHASE_XFER;
                                tm_val = FIRST_CE_CYC;
                                rp_load = 1'b1;
                            end else if (is_optional(pkt_type) &&
                                opt_cnt_q < `MAX_OPT_PKTS) begin
                                opt_cnt_d = opt_cnt_q + 4'h1;
                            end else begin
                                fault_d = 1'b1;
                            end
                        end
                        default: fault_d = 1'b1;
                    endcase
                end
            end
            `PHASE_XFER: begin
                if (good_pkt) begin
                    if (pkt_type == `PH_CTRL_ERR) begin
                        tm_load = 1'b1;
                        tm_val = CE_GAP_CYC;
                        take_ce = 1'b1;
                    end else if (pkt_type == `PH_RECT_PWR) begin
                        rp_load = 1'b1;
                    end else if (pkt_type == `PH_END_XFER) begin
                        power_d = 1'b0;
                        phase_d = `PHASE_SEL;
                        tm_load = 1'b1;
                        tm_val = SEL_PERIOD_CYC;
                    end else if (pkt_type != `PH_CHG_STAT &&
                        (!is_optional(pkt_type) ||
                        pkt_type == `PH_HOLDOFF)) begin
                        fault_d = 1'b1;
                    end
                end
                // expiry wins unless the same packet restarts that timer or ends transfer
                if (phase_d == `PHASE_XFER &&
                    ((tm_exp && !take_ce) || (rp_exp && !rp_load)))
                    fault_d = 1'b1;
            end
            `PHASE_OFF: begin
                // coil stays driven for the removal delay, then drops
                if (tm_exp) begin
                    power_d = 1'b0;
                    phase_d = `PHASE_SEL;
                    tm_load = 1'b1;
                    tm_val = SEL_PERIOD_CYC;
                end
            end
            default: begin
                phase_d = `PHASE_SEL;
                power_d = 1'b0;
            end
        endcase
        // every fault removes power after the removal delay
        if (fault_d) begin
            phase_d = `PHASE_OFF;
            tm_load = 1'b1;
            tm_val = REMOVE_DLY_CYC;
            tmo_armed_d = 1'b0;
        end
    end

    // state registers
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            phase_q <= `PHASE_SEL;
            id_st_q <= ID_WAIT_ID;
            opt_cnt_q <= 4'h0;
            fault_q <= 1'b0;
            power_on_q <= 1'b0;
            tmo_armed_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            id_st_q <= id_st_d;
            opt_cnt_q <= opt_cnt_d;
            fault_q <= fault_d;
            power_on_q <= power_d;
            tmo_armed_q <= tmo_armed_d;
        end
    end

    // operating point: fixed outside transfer, clamped during it
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            period_q <= `PER_PING;
            pend_ce_q <= 1'b0;
            ce_val_q <= 8'sh00;
        end else if (phase_q != `PHASE_XFER) begin
            period_q <= `PER_PING;
            pend_ce_q <= 1'b0;
        end else begin
            if (take_ce) begin
                ce_val_q <= pkt_msg0;
                pend_ce_q <= 1'b1;
            end else if (st_exp && pend_ce_q) begin
                pend_ce_q <= 1'b0;
                // positive error asks more power: shorter period
                if (ce_val_q[7]) begin
                    if (period_q + {8'h00, (~ce_val_q + 8'h01)} >
                        `PER_MAX)
                        period_q <= `PER_MAX;
                    else
                        period_q <= period_q +
                            {8'h00, (~ce_val_q + 8'h01)};
                end else begin
                    if (period_q < `PER_MIN + {8'h00, ce_val_q})
                        period_q <= `PER_MIN;
                    else
                        period_q <= period_q - {8'h00, ce_val_q};
                end
            end
        end
    end
endmodule

// ### testbench/wppc_phase_ctrl_sva.sv
// assertion checker for the phase controller ports
`timescale 1ns/1ns
`include "wpc_consts.vh"
module wppc_sva (
    input logic clk_sys,
    input logic rst_n,
    input logic hdr_start,
    input logic pkt_valid,
    input logic [7:0] pkt_type,
    input logic [7:0] pkt_msg0,
    input logic pkt_csum_ok,
    input logic rx_seen,
    input logic power_on_q,
    input logic [15:0] period_q,
    input logic [2:0] phase_q,
    input logic fault_q
);
    // ****************
    // properties
    // ****************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    logic ok;
    // only checksum-clean packets count
    assign ok = pkt_valid && pkt_csum_ok;
    // fault decided: removal state opens at once
    sequence seq_fault;
        fault_q && phase_q == `PHASE_OFF;
    endsequence
    // hold-off before power drops, then back to selection
    sequence seq_remove;
        (phase_q == `PHASE_OFF)[*8] ##[1:40]
            (phase_q == `PHASE_SEL && !power_on_q);
    endsequence
    chk_removal_delay: assert property (
        fault_q |-> seq_remove) else $error("removal sequence wrong");
    chk_removal_hold: assert property (
        fault_q |-> power_on_q ##1 power_on_q)
        else $error("power dropped before the delay");
    chk_ping_advance: assert property (
        phase_q == `PHASE_PING && ok && pkt_type == `PH_SIG_STRENGTH
        |=> phase_q == `PHASE_IDCFG) else $error("ping did not advance");
    chk_ping_other: assert property (
        phase_q == `PHASE_PING && ok && pkt_type != `PH_SIG_STRENGTH
        |=> seq_fault) else $error("wrong ping packet kept power");
    chk_fixed_point: assert property (
        phase_q inside {`PHASE_PING, `PHASE_IDCFG}
        |-> period_q == `PER_PING && power_on_q)
        else $error("operating point moved");
    chk_bad_csum: assert property (
        phase_q == `PHASE_IDCFG && pkt_valid && !pkt_csum_ok
        |=> phase_q != `PHASE_XFER) else $error("bad checksum advanced");
    chk_out_of_seq: assert property (
        phase_q == `PHASE_XFER && ok && pkt_type inside {`PH_SIG_STRENGTH,
        `PH_CONFIG, `PH_IDENT, `PH_EXT_IDENT, `PH_HOLDOFF} |=> seq_fault)
        else $error("sequence violation kept power");
    chk_end_xfer: assert property (
        phase_q == `PHASE_XFER && ok && pkt_type == `PH_END_XFER
        |=> phase_q == `PHASE_SEL && !power_on_q)
        else $error("end transfer kept power");
    chk_settle_hold: assert property (
        phase_q == `PHASE_XFER && ok && pkt_type == `PH_CTRL_ERR
        |=> ($stable(period_q))[*4]) else $error("period moved early");
    chk_period_range: assert property (
        phase_q == `PHASE_XFER |-> period_q >= `PER_MIN
        && period_q <= `PER_MAX) else $error("period out of range");
endmodule

bind wppc_phase_ctrl wppc_sva u_sva (.clk_sys(clk_sys), .rst_n(rst_n),
    .hdr_start(hdr_start), .pkt_valid(pkt_valid), .pkt_type(pkt_type),
    .pkt_msg0(pkt_msg0), .pkt_csum_ok(pkt_csum_ok), .rx_seen(rx_seen),
    .power_on_q(power_on_q), .period_q(period_q), .phase_q(phase_q),
    .fault_q(fault_q));

// ### testbench/wppc_rx_model.sv
// receiver model: one packet per call, listener response level
`timescale 1ns/1ns
module wppc_rx_model (
    input logic clk_sys,
    output logic hdr_start,
    output logic pkt_valid,
    output logic [7:0] pkt_type,
    output logic [7:0] pkt_msg0,
    output logic pkt_csum_ok,
    output logic rx_seen
);
    // quiet lines at time zero
    initial begin
        hdr_start = 1'h0;
        pkt_valid = 1'h0;
        pkt_type = 8'h00;
        pkt_msg0 = 8'h00;
        pkt_csum_ok = 1'h0;
        rx_seen = 1'h0;
    end
    // response level for the selection listener
    task listen(input logic v);
        @(posedge clk_sys);
        rx_seen <= v;
    endtask
    // header start bit, then packet end with checksum verdict
    task send(input logic [7:0] t, input logic [7:0] m, input logic ok);
        @(posedge clk_sys);
        hdr_start <= 1'h1;
        @(posedge clk_sys);
        hdr_start <= 1'h0;
        repeat (6) @(posedge clk_sys);
        pkt_valid <= 1'h1;
        pkt_type <= t;
        pkt_msg0 <= m;
        pkt_csum_ok <= ok;
        @(posedge clk_sys);
        // released bytes flip so stale data never looks fresh
        pkt_valid <= 1'h0;
        pkt_type <= ~t;
        pkt_msg0 <= ~m;
        pkt_csum_ok <= ~ok;
    endtask
endmodule

// ### testbench/wppc_phase_ctrl_tb.sv
// self-checking bench for the phase controller
`timescale 1ns/1ns
`include "wpc_consts.vh"
module wppc_phase_ctrl_tb;
    // ****************
    // setup
    // ****************
    localparam int PING = 40, NXT = 30, FCE = 60, CEG = 80;
    localparam int RPG = 150, RMV = 10, STL = 5;
    localparam logic [7:0] OPT [7] = '{8'h06, 8'h18, 8'hf2, 8'h33,
        8'h06, 8'h18, 8'hf2};
    logic clk_sys = 1'h0;
    logic rst_n = 1'h0;
    wire hdr_start, pkt_valid, pkt_csum_ok, rx_seen, power_on_q, fault_q;
    wire [7:0] pkt_type, pkt_msg0;
    wire [15:0] period_q;
    wire [2:0] phase_q;
    int num_errors = 0;
    int compares = 0;
    // 125 MHz clock
    always #4 clk_sys = ~clk_sys;
    wppc_rx_model u_rx (.clk_sys(clk_sys), .hdr_start(hdr_start),
        .pkt_valid(pkt_valid), .pkt_type(pkt_type), .pkt_msg0(pkt_msg0),
        .pkt_csum_ok(pkt_csum_ok), .rx_seen(rx_seen));
    // short counts keep the run brief
    wppc_phase_ctrl #(.SEL_PERIOD_CYC(100), .SEL_BURST_CYC(20),
        .PING_WIN_CYC(PING), .NEXT_PKT_CYC(NXT), .FIRST_CE_CYC(FCE),
        .CE_GAP_CYC(CEG), .RP_GAP_CYC(RPG), .REMOVE_DLY_CYC(RMV),
        .SETTLE_CYC(STL)) dut (.clk_sys(clk_sys), .rst_n(rst_n),
        .hdr_start(hdr_start), .pkt_valid(pkt_valid), .pkt_type(pkt_type),
        .pkt_msg0(pkt_msg0), .pkt_csum_ok(pkt_csum_ok), .rx_seen(rx_seen),
        .power_on_q(power_on_q), .period_q(period_q), .phase_q(phase_q),
        .fault_q(fault_q));
    // ****************
    // helpers
    // ****************
    task chk(input string what, input logic [15:0] seen,
        input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task report_and_stop;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // sample just after the edge so its updates have landed
    task tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task wait_ph(input logic [2:0] p, input int lim);
        for (int i = 0; i < lim && phase_q !== p; i++) tick(1);
        chk("phase wait", phase_q, p);
        if (phase_q !== p) report_and_stop();
    endtask
    // fault pulse within lim cycles, then unpowered selection
    task removal(input int lim);
        tick(0);
        for (int i = 0; i < lim && fault_q !== 1'h1; i++) tick(1);
        chk("fault", fault_q, 1'h1);
        chk("removing", phase_q, `PHASE_OFF);
        chk("removal delay", power_on_q, 1'h1);
        wait_ph(`PHASE_SEL, RMV + 4);
        chk("power off", power_on_q, 1'h0);
    endtask
    task get_ping;
        u_rx.listen(1'h1);
        wait_ph(`PHASE_PING, 400);
        chk("ping power", power_on_q, 1'h1);
        chk("ping period", period_q, `PER_PING);
        u_rx.listen(1'h0);
    endtask
    task go_idcfg;
        get_ping();
        u_rx.send(`PH_SIG_STRENGTH, 8'h00, 1'h0);
        tick(0);
        chk("bad csum", phase_q, `PHASE_PING);
        u_rx.send(`PH_SIG_STRENGTH, 8'hff, 1'h1);
        tick(0);
        chk("to id", phase_q, `PHASE_IDCFG);
    endtask
    // full sequence with all seven optional packets
    task go_xfer(input logic ext);
        go_idcfg();
        u_rx.send(`PH_IDENT, {ext, 7'h00}, 1'h1);
        if (ext) begin
            u_rx.send(`PH_EXT_IDENT, 8'h00, 1'h1);
        end
        for (int i = 0; i < 7; i++) begin
            u_rx.send(OPT[i], 8'h00, 1'h1);
            tick(0);
            chk("id period", period_q, `PER_PING);
        end
        u_rx.send(`PH_CONFIG, 8'h00, 1'h0);
        tick(0);
        chk("cfg csum", phase_q, `PHASE_IDCFG);
        u_rx.send(`PH_CONFIG, 8'h00, 1'h1);
        tick(0);
        chk("to xfer", phase_q, `PHASE_XFER);
    endtask
    // ****************
    // scenarios
    // ****************
    task s_xfer;
        logic [15:0] d;
        go_xfer(1'h1);
        u_rx.send(`PH_CTRL_ERR, 8'h05, 1'h1);
        tick(0);
        chk("ce hold", period_q, `PER_PING);
        tick(STL + 3);
        d = period_q > `PER_PING ? period_q - `PER_PING
            : `PER_PING - period_q;
        chk("ce step", d, 16'h0005);
        u_rx.send(`PH_RECT_PWR, 8'h10, 1'h1);
        u_rx.send(`PH_CHG_STAT, 8'h20, 1'h1);
        u_rx.send(8'h33, 8'h00, 1'h1);
        tick(0);
        chk("xfer stays", phase_q, `PHASE_XFER);
        u_rx.send(`PH_END_XFER, 8'h00, 1'h1);
        tick(0);
        chk("end phase", phase_q, `PHASE_SEL);
        chk("end power", power_on_q, 1'h0);
    endtask
    task s_ping_faults;
        get_ping();
        removal(PING + 10);
        get_ping();
        u_rx.send(`PH_IDENT, 8'h00, 1'h1);
        removal(4);
    endtask
    task s_id_faults;
        go_idcfg();
        u_rx.send(`PH_IDENT, 8'h00, 1'h1);
        u_rx.send(`PH_EXT_IDENT, 8'h00, 1'h1);
        removal(4);
        go_idcfg();
        u_rx.send(`PH_IDENT, 8'h00, 1'h1);
        removal(NXT + 10);
        go_idcfg();
        u_rx.send(`PH_IDENT, 8'h00, 1'h1);
        for (int i = 0; i < 8; i++) u_rx.send(OPT[i % 7], 8'h00, 1'h1);
        removal(4);
    endtask
    task s_xfer_faults;
        go_xfer(1'h0);
        removal(FCE + 10);
        go_xfer(1'h0);
        u_rx.send(`PH_CTRL_ERR, 8'h00, 1'h1);
        u_rx.send(`PH_RECT_PWR, 8'h00, 1'h1);
        removal(CEG + 10);
        go_xfer(1'h0);
        u_rx.send(`PH_CTRL_ERR, 8'h00, 1'h1);
        u_rx.send(`PH_IDENT, 8'h00, 1'h1);
        removal(4);
        go_xfer(1'h0);
        // control errors keep coming, rectified power never does
        repeat (4) begin
            u_rx.send(`PH_CTRL_ERR, 8'hfb, 1'h1);
            tick(25);
        end
        u_rx.send(`PH_CTRL_ERR, 8'h00, 1'h1);
        removal(40);
    endtask
    // main sequence
    initial begin
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'h1;
        tick(1);
        chk("rst phase", phase_q, `PHASE_SEL);
        chk("rst period", period_q, `PER_PING);
        s_xfer();
        s_ping_faults();
        s_id_faults();
        s_xfer_faults();
        report_and_stop();
    end
endmodule
